// ==== logic/prcg_top.sv ====
// prcg_top: peripheral reset and clock gate registers behind AXI4-Lite.
// assumes one clock, aclk, and a synchronous active-low reset.
// gated clocks leave through latch-based gates; everything else is a flop.
`timescale 1ns/1ps
`default_nettype none

module prcg_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // peripheral reset releases, active low resets
    output logic dual_timer_reset_release,
    output logic sleep_counter_reset_release,
    output logic whole_chip_reset_release,
    output logic power_domain_four_reset_release,
    output logic radio_low_power_reset_release,
    // clock gate enables and gated clocks
    output logic [31:0] clock_gate_enable,
    output logic [31:0] gated_clk
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic same_word(
        input logic [31:0] a,
        input logic [31:0] b
    );
        return a[31:2] == b[31:2];
    endfunction

    // writable gate bits; firmware-owned bits stay writable on purpose
    localparam logic [31:0] GATE_MASK =
        (32'h1 << prcg_pkg::CALIBRATION_CLOCK_GATE)
        | (32'h1 << prcg_pkg::SECOND_TWOWIRE_CORE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::THIRD_QUADRATURE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::SECOND_QUADRATURE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::FIRST_QUADRATURE_CLOCK_GATE)
        | (32'h1FF << prcg_pkg::FIRMWARE_GATES_LO)
        | (32'h1 << prcg_pkg::SECOND_SERIAL_PORT_LINE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::SECOND_SERIAL_PORT_CORE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::FIRST_SERIAL_PORT_LINE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::FIRST_SERIAL_PORT_CORE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::SECOND_WATCHDOG_CLOCK_GATE)
        | (32'h1 << prcg_pkg::FIRST_WATCHDOG_CLOCK_GATE)
        | (32'h1 << prcg_pkg::GENERAL_TIMER_CLOCK_GATE)
        | (32'h1 << prcg_pkg::GPIO_CLOCK_GATE)
        | (32'h1 << prcg_pkg::DUAL_TIMER_CLOCK_GATE)
        | (32'h1 << prcg_pkg::FIRST_TWOWIRE_CORE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::SECOND_SERIAL_PERIPH_CORE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::FIRST_SERIAL_PERIPH_CORE_CLOCK_GATE)
        | (32'h1 << prcg_pkg::SERIAL_FLASH_CLOCK_GATE);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic aw_hold_q;
    logic aw_hold_d;
    logic w_hold_q;
    logic w_hold_d;
    prcg_pkg::prcg_wreq_s wreq_q;
    prcg_pkg::prcg_wreq_s wreq_d;
    logic awready_q;
    logic awready_d;
    logic wready_q;
    logic wready_d;
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    logic arready_q;
    logic arready_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    logic [11:0] rst_one_q;
    logic [11:0] rst_one_d;
    prcg_pkg::prcg_aon_s aon_q;
    prcg_pkg::prcg_aon_s aon_d;
    logic [31:0] gate_q;
    logic [31:0] gate_d;

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    wire aw_fire;
    wire w_fire;
    wire wr_go;
    wire wr_one;
    wire wr_aon;
    wire wr_gate;
    wire wr_hit;

    assign aw_fire = s_axi_awvalid & awready_q;
    assign w_fire = s_axi_wvalid & wready_q;
    // commit only once both halves are held and no response is pending
    assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
    assign wr_one = wr_go & same_word(wreq_q.addr, prcg_pkg::ADDR_RESET_ONE);
    assign wr_aon = wr_go & same_word(wreq_q.addr, prcg_pkg::ADDR_AON_RESET);
    assign wr_gate = wr_go & same_word(wreq_q.addr, prcg_pkg::ADDR_CLOCK_GATE_0);
    assign wr_hit = wr_one | wr_aon | wr_gate;

    // address and data may arrive in either order
    assign aw_hold_d = wr_go ? 1'b0 : (aw_fire | aw_hold_q);
    assign w_hold_d = wr_go ? 1'b0 : (w_fire | w_hold_q);
    assign wreq_d.addr = aw_fire ? s_axi_awaddr : wreq_q.addr;
    assign wreq_d.data = w_fire ? s_axi_wdata : wreq_q.data;
    assign wreq_d.strb = w_fire ? s_axi_wstrb : wreq_q.strb;
    assign bvalid_d = wr_go | (bvalid_q & ~s_axi_bready);
    assign bresp_d = wr_go ? (wr_hit ? prcg_pkg::RESP_OKAY : prcg_pkg::RESP_DECERR) : bresp_q;
    // no new address or data until the response is taken
    assign awready_d = ~aw_hold_d & ~bvalid_d;
    assign wready_d = ~w_hold_d & ~bvalid_d;

    // ------------------------------------------------------------
    // register updates
    // ------------------------------------------------------------
    wire [31:0] one_new;
    wire [31:0] aon_new;
    wire [31:0] gate_new;

    assign one_new = merge({20'h0, rst_one_q}, wreq_q.data, wreq_q.strb);
    assign aon_new = merge({24'h0, aon_q}, wreq_q.data, wreq_q.strb);
    assign gate_new = merge(gate_q, wreq_q.data, wreq_q.strb);

    assign rst_one_d = wr_one ? one_new[11:0] : rst_one_q;
    // chip reset bit reads 0 for one cycle, then sets itself again
    assign aon_d = wr_aon ? (aon_new[7:0] & prcg_pkg::AON_RESET_MASK)
        : (aon_q | 8'h01);
    assign gate_d = wr_gate ? (gate_new & GATE_MASK) : gate_q;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire ar_fire;
    wire rd_one;
    wire rd_aon;
    wire rd_gate;
    wire rd_hit;
    wire [31:0] rd_word;

    assign ar_fire = s_axi_arvalid & arready_q;
    assign rd_one = same_word(s_axi_araddr, prcg_pkg::ADDR_RESET_ONE);
    assign rd_aon = same_word(s_axi_araddr, prcg_pkg::ADDR_AON_RESET);
    assign rd_gate = same_word(s_axi_araddr, prcg_pkg::ADDR_CLOCK_GATE_0);
    // unmapped words read as zero
    assign rd_word = rd_one ? {20'h0, rst_one_q}
        : rd_aon ? {24'h0, aon_q}
        : rd_gate ? gate_q
        : 32'h0;
    assign rd_hit = rd_one | rd_aon | rd_gate;

    assign rvalid_d = ar_fire | (rvalid_q & ~s_axi_rready);
    assign arready_d = ~rvalid_d;
    assign rdata_d = ar_fire ? rd_word : rdata_q;
    assign rresp_d = ar_fire ? (rd_hit ? prcg_pkg::RESP_OKAY : prcg_pkg::RESP_DECERR) : rresp_q;

    // ------------------------------------------------------------
    // bus flops
    // ------------------------------------------------------------
    // address, data and strobes of the write in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            wreq_q <= '0;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            wreq_q <= wreq_d;
        end
    end

    // readies stay low through reset so nothing is taken early
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
        end
    end

    // response stands until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= prcg_pkg::RESP_OKAY;
        end else begin
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
        end
    end

    // read word is frozen at the taking edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= 32'h0;
            rresp_q <= prcg_pkg::RESP_OKAY;
        end else begin
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // dual timer release word; only bit 0 leaves the block
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_one_q <= prcg_pkg::RESET_ONE_RST;
        end else begin
            rst_one_q <= rst_one_d;
        end
    end

    // always-on resets; the chip reset bit restores itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aon_q <= prcg_pkg::AON_RESET_RST;
        end else begin
            aon_q <= aon_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_q <= prcg_pkg::CLOCK_GATE_0_RST;
        end else begin
            gate_q <= gate_d;
        end
    end

    // ------------------------------------------------------------
    // clock gates
    // ------------------------------------------------------------
    // enable is caught while aclk is low, so a change never clips a pulse
    logic [31:0] gate_latched;

    always_latch begin
        if (!aclk) begin
            gate_latched <= gate_q;
        end
    end

    assign gated_clk = {32{aclk}} & gate_latched;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    assign dual_timer_reset_release = rst_one_q[prcg_pkg::DUAL_TIMER_RESET_RELEASE];
    assign sleep_counter_reset_release = aon_q.sleep_counter_reset_release;
    assign whole_chip_reset_release = aon_q.whole_chip_reset_release;
    // left writable; boot firmware owns them
    assign power_domain_four_reset_release = aon_q.power_domain_four_reset_release;
    assign radio_low_power_reset_release = aon_q.radio_low_power_reset_release;
    assign clock_gate_enable = gate_q;

endmodule

`default_nettype wire

// ==== logic/prcg_pkg.sv ====
// prcg_pkg: constants and carriers of the peripheral reset and clock gate block.
// assumes a 32-bit AXI4-Lite register bus with absolute byte addresses.
package prcg_pkg;

    // ------------------------------------------------------------
    // register addresses (absolute, word aligned)
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_RESET_ONE = 32'h4000B008;
    localparam logic [31:0] ADDR_CLOCK_GATE_0 = 32'h4000B00C;
    localparam logic [31:0] ADDR_AON_RESET = 32'h4000F010;

    // ------------------------------------------------------------
    // reset values and implemented-bit masks
    // ------------------------------------------------------------
    localparam logic [11:0] RESET_ONE_RST = 12'hFFF;
    localparam logic [7:0] AON_RESET_RST = 8'h1B;
    localparam logic [7:0] AON_RESET_MASK = 8'h1B;
    localparam logic [31:0] CLOCK_GATE_0_RST = 32'h627FF9BE;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DUAL_TIMER_RESET_RELEASE = 0;
    localparam int CALIBRATION_CLOCK_GATE = 30;
    localparam int SECOND_TWOWIRE_CORE_CLOCK_GATE = 29;
    localparam int THIRD_QUADRATURE_CLOCK_GATE = 28;
    localparam int SECOND_QUADRATURE_CLOCK_GATE = 27;
    localparam int FIRST_QUADRATURE_CLOCK_GATE = 26;
    localparam int FIRMWARE_GATES_LO = 17;
    localparam int SECOND_SERIAL_PORT_LINE_CLOCK_GATE = 16;
    localparam int SECOND_SERIAL_PORT_CORE_CLOCK_GATE = 15;
    localparam int FIRST_SERIAL_PORT_LINE_CLOCK_GATE = 14;
    localparam int FIRST_SERIAL_PORT_CORE_CLOCK_GATE = 13;
    localparam int SECOND_WATCHDOG_CLOCK_GATE = 12;
    localparam int FIRST_WATCHDOG_CLOCK_GATE = 11;
    localparam int GENERAL_TIMER_CLOCK_GATE = 8;
    localparam int GPIO_CLOCK_GATE = 7;
    localparam int DUAL_TIMER_CLOCK_GATE = 5;
    localparam int FIRST_TWOWIRE_CORE_CLOCK_GATE = 4;
    localparam int SECOND_SERIAL_PERIPH_CORE_CLOCK_GATE = 3;
    localparam int FIRST_SERIAL_PERIPH_CORE_CLOCK_GATE = 2;
    localparam int SERIAL_FLASH_CLOCK_GATE = 1;

    // ------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] unused_hi;
        logic power_domain_four_reset_release;
        logic radio_low_power_reset_release;
        logic unused_two;
        logic sleep_counter_reset_release;
        logic whole_chip_reset_release;
    } prcg_aon_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } prcg_wreq_s;

endpackage

// ==== tb/prcg_sva.sv ====
// prcg_sva: concurrent checks on the reset and clock gate register block.
// assumes it is bound into prcg_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module prcg_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write side of the bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    // releases and gates
    input wire logic dual_timer_reset_release,
    input wire logic sleep_counter_reset_release,
    input wire logic whole_chip_reset_release,
    input wire logic [31:0] clock_gate_enable
);
    logic [31:0] a_q;
    logic [31:0] d_q;
    logic f_q;
    logic un;
    // ----------------------------------------
    // last accepted write, flagged when all four strobes are set
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready)
            a_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) begin
            d_q <= s_axi_wdata;
            f_q <= s_axi_wstrb == 4'hF;
        end
    end
    assign un = a_q != prcg_pkg::ADDR_CLOCK_GATE_0 && a_q != prcg_pkg::ADDR_AON_RESET
        && a_q != prcg_pkg::ADDR_RESET_ONE;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_done(logic [31:0] a);
        $rose(s_axi_bvalid) && a_q == a && f_q && s_axi_bresp == prcg_pkg::RESP_OKAY;
    endsequence
    sequence chip_pulse;
        !whole_chip_reset_release ##1 whole_chip_reset_release;
    endsequence
    AST_RST_VALS: assert property ($rose(aresetn) |-> clock_gate_enable == 32'h627FF9BE
        && whole_chip_reset_release && sleep_counter_reset_release && dual_timer_reset_release)
        else $error("register outputs wrong after reset");
    AST_GATE_UNDEF: assert property ((clock_gate_enable & 32'h80000641) == 32'h0)
        else $error("undefined clock gate bit set");
    AST_GATE_WRITE: assert property (wr_done(prcg_pkg::ADDR_CLOCK_GATE_0) |->
        clock_gate_enable == (d_q & 32'h7FFFF9BE))
        else $error("clock gates differ from written word");
    AST_SLEEP_WRITE: assert property (wr_done(prcg_pkg::ADDR_AON_RESET) |->
        sleep_counter_reset_release == d_q[1])
        else $error("sleep counter release differs from written bit");
    AST_DT_WRITE: assert property (wr_done(prcg_pkg::ADDR_RESET_ONE) |->
        dual_timer_reset_release == d_q[0])
        else $error("dual timer release differs from written bit");
    AST_CHIP_LOW: assert property (wr_done(prcg_pkg::ADDR_AON_RESET) ##0 !d_q[0] |-> chip_pulse)
        else $error("chip reset pulse missing after write of zero");
    AST_CHIP_SHORT: assert property ($fell(whole_chip_reset_release) |=> whole_chip_reset_release)
        else $error("chip reset held longer than one cycle");
    AST_DECERR: assert property ($rose(s_axi_bvalid) && un |-> s_axi_bresp == prcg_pkg::RESP_DECERR)
        else $error("unmapped write not refused");
    AST_B_QUICK: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
endmodule
bind prcg_top prcg_sva u_prcg_sva (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: drives prcg_top over AXI4-Lite and checks registers and outputs.
// assumes the bench is the only bus master; expectations come from a model kept here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [31:0] GM = 32'h7FFFF9BE;
    localparam logic [31:0] FW = 32'h43FE0000;
    localparam logic [31:0] AG = prcg_pkg::ADDR_CLOCK_GATE_0;
    localparam logic [31:0] AA = prcg_pkg::ADDR_AON_RESET;
    localparam logic [31:0] AR = prcg_pkg::ADDR_RESET_ONE;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, clock_gate_enable, gated_clk, g_m, a_m, r_m;
    logic dual_timer_reset_release, sleep_counter_reset_release, whole_chip_reset_release;
    logic power_domain_four_reset_release, radio_low_power_reset_release;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;

    prcg_top DUT (.*);

    always #2 aclk = ~aclk;
    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t response %h expected %h", $time, got, exp);
        end
    endtask
    // response notes are taken off in order as each handshake completes
    always @(posedge aclk) begin
        cyc++;
        if (aresetn && s_axi_bvalid && s_axi_bready && bq.size() > 0)
            cmp_resp(s_axi_bresp, bq.pop_front());
        if (aresetn && s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
            cmp_resp(s_axi_rresp, rq[0][33:32]);
            cmp_word(s_axi_rdata, rq[0][31:0]);
            void'(rq.pop_front());
        end
        // a hang ends here as a failure
        if (cyc == 5000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // register model and bus tasks
    // ----------------------------------------
    function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s,
                                        input logic [31:0] m);
        for (int i = 0; i < 4; i++)
            if (s[i])
                o[8*i+:8] = n[8*i+:8];
        return o & m;
    endfunction
    function automatic logic [31:0] model(input logic [31:0] a);
        return a == AG ? g_m : a == AA ? a_m : a == AR ? r_m : 32'h0;
    endfunction
    function automatic logic [1:0] resp(input logic [31:0] a);
        return (a == AG || a == AA || a == AR) ? prcg_pkg::RESP_OKAY : prcg_pkg::RESP_DECERR;
    endfunction
    // sampled in the high phase so the gated clocks show their enables
    task automatic chk_out();
        #1;
        cmp_word(clock_gate_enable, g_m);
        cmp_word(gated_clk, g_m);
        cmp_word({26'h0, dual_timer_reset_release, power_domain_four_reset_release, radio_low_power_reset_release,
                  1'b0, sleep_counter_reset_release, whole_chip_reset_release}, {26'h0, r_m[0], a_m[4:0]});
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        logic bd;
        bd = 1'b0;
        @(posedge aclk);
        bq.push_back(resp(a));
        if (a == AG) g_m = mrg(g_m, d, s, GM);
        if (a == AA) a_m = mrg(a_m, d, s, 32'h1B) | 32'h1;
        if (a == AR) r_m = mrg(r_m, d, s, 32'hFFF);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bd) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                bd = 1'b1;
            end
        end
        chk_out();
    endtask
    task automatic rd(input logic [31:0] a);
        logic rdn;
        rdn = 1'b0;
        @(posedge aclk);
        rq.push_back({resp(a), model(a)});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rdn) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                rdn = 1'b1;
            end
        end
    endtask
    task automatic rst();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        g_m = 32'h627FF9BE;
        a_m = 32'h1B;
        r_m = 32'hFFF;
        @(posedge aclk);
        chk_out();
        rd(AG);
        rd(AA);
        rd(AR);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] a;
        logic [31:0] v;
        logic [31:0] fm;
        logic [31:0] tbl[4];
        void'($urandom(32'h48ee));
        tbl = '{AG, AA, AR, 32'h4000F014};
        rst();
        // walking one then walking zero; firmware-owned gates keep their value
        for (int i = 0; i < 64; i++) begin
            v = i[5] ? ~(32'h1 << i[4:0]) : 32'h1 << i[4:0];
            wr(AG, (v & ~FW) | (g_m & FW), 4'hF);
            rd(AG);
        end
        wr(AA, 32'h18, 4'hF);
        wr(AA, 32'h1A, 4'hF);
        wr(AA, 32'hFF, 4'h1);
        rd(AA);
        wr(AR, 32'h0, 4'hF);
        rd(AR);
        wr(AR, 32'hFFF, 4'h3);
        repeat (60) begin
            a = tbl[$urandom_range(3)];
            fm = a == AA ? 32'h18 : FW;
            v = $urandom;
            wr(a, (v & ~fm) | (model(a) & fm), 4'($urandom));
            rd(tbl[$urandom_range(3)]);
        end
        rst();
        wrap_up();
    end
endmodule
`default_nettype wire
